// [rtl/hbi_top.sv]
// Contract
// - Drive controls brake itself, no host command
// - Brake pin select 0..3, 0 unassigned
// - Stopped: motor on for delay after brake
// - Zero delay: motor off with brake together
// - Running speed threshold 0..10000 rpm, default 100
// - Running timeout 0..100 ticks, default 50
// - Running timing on servo-on drop or alarm
// - Output function code 110..666, default 210
// - Digit decode 0..6 to status functions
`timescale 1ns/1ps
`default_nettype none
module hbi_top #(
    parameter int unsigned TICK_CYCLES = hbi_pkg::TICK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        servo_on_in,
    input  wire logic        alarm_in,
    input  wire logic [13:0] motor_speed,
    input  wire logic        position_complete,
    input  wire logic        speed_coincide,
    input  wire logic        rotation_detect,
    input  wire logic        servo_ready,
    input  wire logic        current_limit,
    input  wire logic        overload_warn,
    input  wire logic        overload_fault,
    output logic             motor_enable,
    output logic             brake_interlock_out,
    output logic [2:0]       out_pair_n
);
    logic [1:0]  brake_pin_select_r;
    logic [5:0]  stop_brake_delay_r;
    logic [13:0] run_brake_speed_level_r;
    logic [6:0]  run_brake_timeout_r;
    logic [9:0]  output_function_select_r;
    logic        son_s1_r, son_s2_r, alm_s1_r, alm_s2_r;
    logic        son_sync, alm_sync, servo_req, tick;
    hbi_pkg::hbi_state_t state_r, state_nxt;
    logic [6:0]  cnt_r, cnt_nxt;
    logic [3:0]  dig0, dig1, dig2;
    logic [2:0]  func_pair;
    logic        wr_en, rd_en;

    // Digit extraction for a three-digit decimal code
    function automatic logic [3:0] dec_digit(input logic [9:0] v, input int unsigned pos);
        logic [9:0] q;
        q = v;
        for (int i = 0; i < 2; i++) begin
            if (i < pos) q = 10'(q / 10);
        end
        return 4'(q % 10);
    endfunction : dec_digit

    // Function selection of one pair, active-level status
    function automatic logic sel_func(input logic [3:0] d, input logic first_pair,
                                      input logic pc, input logic sc, input logic rd,
                                      input logic sr, input logic cl, input logic bk,
                                      input logic ow, input logic of);
        logic r;
        r = 1'b0;
        case (d)
            4'h0:    r = first_pair ? (pc | sc) : 1'b0;
            4'h1:    r = rd;
            4'h2:    r = sr;
            4'h3:    r = cl;
            4'h4:    r = bk;
            4'h5:    r = ow;
            4'h6:    r = of;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : sel_func

    hbi_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // Servo-on and alarm pin inputs pass two flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            son_s1_r <= 1'b0;
            son_s2_r <= 1'b0;
        end else begin
            son_s1_r <= servo_on_in;
            son_s2_r <= son_s1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alm_s1_r <= 1'b0;
            alm_s2_r <= 1'b0;
        end else begin
            alm_s1_r <= alarm_in;
            alm_s2_r <= alm_s1_r;
        end
    end
    assign son_sync  = son_s2_r;
    assign alm_sync  = alm_s2_r;
    assign servo_req = son_sync & ~alm_sync;

    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign pslverr = psel & penable & ((paddr > hbi_pkg::ADDR_STATUS) | (paddr[1:0] != 2'h0));

    // Settings; out-of-range writes are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brake_pin_select_r       <= hbi_pkg::PIN_SEL_RST;
            stop_brake_delay_r       <= hbi_pkg::STOP_DLY_RST;
            run_brake_speed_level_r  <= hbi_pkg::RUN_SPD_RST;
            run_brake_timeout_r      <= hbi_pkg::RUN_TMO_RST;
            output_function_select_r <= hbi_pkg::OUT_FUNC_RST;
        end else if (wr_en && !pslverr) begin
            if (paddr == hbi_pkg::ADDR_CTRL) begin
                // Values above 3 are refused, not truncated
                if (pwdata[31:2] == 30'h0)
                    brake_pin_select_r <= pwdata[hbi_pkg::CTRL_PIN_SEL_LSB +: 2];
            end else if (paddr == hbi_pkg::ADDR_STOP_DLY) begin
                if (pwdata <= 32'(hbi_pkg::STOP_DLY_MAX))
                    stop_brake_delay_r <= pwdata[5:0];
            end else if (paddr == hbi_pkg::ADDR_RUN_SPD) begin
                if (pwdata <= 32'(hbi_pkg::RUN_SPD_MAX))
                    run_brake_speed_level_r <= pwdata[13:0];
            end else if (paddr == hbi_pkg::ADDR_RUN_TMO) begin
                if (pwdata <= 32'(hbi_pkg::RUN_TMO_MAX))
                    run_brake_timeout_r <= pwdata[6:0];
            end else if (paddr == hbi_pkg::ADDR_OUT_FUNC) begin
                if (pwdata >= 32'(hbi_pkg::OUT_FUNC_MIN) &&
                    pwdata <= 32'(hbi_pkg::OUT_FUNC_MAX) &&
                    dec_digit(pwdata[9:0], 0) <= 4'h6 &&
                    dec_digit(pwdata[9:0], 1) inside {[4'h1:4'h6]} &&
                    dec_digit(pwdata[9:0], 2) inside {[4'h1:4'h6]})
                    output_function_select_r <= pwdata[9:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == hbi_pkg::ADDR_CTRL) begin
                prdata <= {30'h0, brake_pin_select_r};
            end else if (paddr == hbi_pkg::ADDR_STOP_DLY) begin
                prdata <= {26'h0, stop_brake_delay_r};
            end else if (paddr == hbi_pkg::ADDR_RUN_SPD) begin
                prdata <= {18'h0, run_brake_speed_level_r};
            end else if (paddr == hbi_pkg::ADDR_RUN_TMO) begin
                prdata <= {25'h0, run_brake_timeout_r};
            end else if (paddr == hbi_pkg::ADDR_OUT_FUNC) begin
                prdata <= {22'h0, output_function_select_r};
            end else if (paddr == hbi_pkg::ADDR_STATUS) begin
                prdata <= {26'h0, state_r, 2'h0, motor_enable, brake_interlock_out};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Brake sequencing is owned here; no brake command port exists
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            hbi_pkg::HBI_OFF: begin
                if (servo_req) state_nxt = hbi_pkg::HBI_ON;
            end
            hbi_pkg::HBI_ON: begin
                if (!servo_req) begin
                    if (motor_speed < run_brake_speed_level_r) begin
                        cnt_nxt = {1'b0, stop_brake_delay_r};
                        state_nxt = (stop_brake_delay_r == 6'h00) ? hbi_pkg::HBI_OFF
                                                                  : hbi_pkg::HBI_STOP_DL;
                    end else begin
                        cnt_nxt   = run_brake_timeout_r;
                        state_nxt = hbi_pkg::HBI_RUN_WT;
                    end
                end
            end
            hbi_pkg::HBI_STOP_DL: begin
                if (tick) cnt_nxt = cnt_r - 7'h01;
                if (tick && cnt_r == 7'h01) state_nxt = hbi_pkg::HBI_OFF;
            end
            hbi_pkg::HBI_RUN_WT: begin
                if (tick && cnt_r != 7'h00) cnt_nxt = cnt_r - 7'h01;
                if (motor_speed < run_brake_speed_level_r || cnt_r == 7'h00 ||
                    (tick && cnt_r == 7'h01)) state_nxt = hbi_pkg::HBI_OFF;
            end
            default: state_nxt = hbi_pkg::HBI_OFF;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= hbi_pkg::HBI_OFF;
            cnt_r   <= 7'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Motor output stays on through the stop delay and the running wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_enable <= 1'b0;
        end else begin
            motor_enable <= (state_nxt != hbi_pkg::HBI_OFF);
        end
    end

    // Brake held released in the running wait until speed or timeout trips
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brake_interlock_out <= 1'b1;
        end else begin
            brake_interlock_out <= (state_nxt == hbi_pkg::HBI_OFF) ||
                                   (state_nxt == hbi_pkg::HBI_STOP_DL);
        end
    end

    assign dig0 = dec_digit(output_function_select_r, 0);
    assign dig1 = dec_digit(output_function_select_r, 1);
    assign dig2 = dec_digit(output_function_select_r, 2);

    always_comb begin
        func_pair[0] = sel_func(dig0, 1'b1, position_complete, speed_coincide, rotation_detect,
                                servo_ready, current_limit, brake_interlock_out,
                                overload_warn, overload_fault);
        func_pair[1] = sel_func(dig1, 1'b0, position_complete, speed_coincide, rotation_detect,
                                servo_ready, current_limit, brake_interlock_out,
                                overload_warn, overload_fault);
        func_pair[2] = sel_func(dig2, 1'b0, position_complete, speed_coincide, rotation_detect,
                                servo_ready, current_limit, brake_interlock_out,
                                overload_warn, overload_fault);
    end

    // Pin select overrides function code on the chosen pair; outputs are active low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_pair_n <= 3'h7;
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (brake_pin_select_r == 2'(p + 1))
                    out_pair_n[p] <= ~brake_interlock_out;
                else
                    out_pair_n[p] <= ~func_pair[p];
            end
        end
    end
endmodule : hbi_top
`default_nettype wire

// [include/hbi_pkg.sv]
package hbi_pkg;
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned TICK_MS         = 10;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;

    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_STOP_DLY   = 12'h004;
    localparam logic [11:0] ADDR_RUN_SPD    = 12'h008;
    localparam logic [11:0] ADDR_RUN_TMO    = 12'h00C;
    localparam logic [11:0] ADDR_OUT_FUNC   = 12'h010;
    localparam logic [11:0] ADDR_STATUS     = 12'h014;

    localparam logic [1:0]  PIN_SEL_RST     = 2'h0;
    localparam logic [5:0]  STOP_DLY_RST    = 6'h00;
    localparam logic [5:0]  STOP_DLY_MAX    = 6'h32;
    localparam logic [13:0] RUN_SPD_RST     = 14'h0064;
    localparam logic [13:0] RUN_SPD_MAX     = 14'h2710;
    localparam logic [6:0]  RUN_TMO_RST     = 7'h32;
    localparam logic [6:0]  RUN_TMO_MAX     = 7'h64;
    localparam logic [9:0]  OUT_FUNC_RST    = 10'h0D2;
    localparam logic [9:0]  OUT_FUNC_MIN    = 10'h06E;
    localparam logic [9:0]  OUT_FUNC_MAX    = 10'h29A;

    localparam int unsigned CTRL_PIN_SEL_LSB = 0;
    localparam int unsigned ST_BRAKE_BIT     = 0;
    localparam int unsigned ST_MOTOR_BIT     = 1;
    localparam int unsigned ST_STATE_LSB     = 4;

    typedef enum logic [1:0] {
        HBI_OFF     = 2'b00,
        HBI_ON      = 2'b01,
        HBI_STOP_DL = 2'b10,
        HBI_RUN_WT  = 2'b11
    } hbi_state_t;
endpackage : hbi_pkg

// [rtl/hbi_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module hbi_tick #(
    parameter int unsigned CYCLES = 1250000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    logic [31:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (cnt_r == CYCLES - 1) begin
            cnt_r <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule : hbi_tick
`default_nettype wire

// [verification/hbi_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module hbi_top_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        servo_on_in,
    input wire logic        alarm_in,
    input wire logic        motor_enable,
    input wire logic        brake_interlock_out,
    input wire logic [2:0]  out_pair_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [1:0] sel_r;
    // Shadow of the brake pin selection, legal values only
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) sel_r <= 2'h0;
        else if (psel && penable && pwrite && paddr == 12'h000 && pwdata < 32'h4) sel_r <= pwdata[1:0];
    a_motor_off_brake: assert property (!motor_enable |-> brake_interlock_out)
        else $error("brake released with motor off");
    a_reset_safe: assert property ($rose(presetn) |-> brake_interlock_out && !motor_enable)
        else $error("unsafe outputs at reset release");
    a_stop_bound: assert property ($rose(brake_interlock_out) |-> ##[0:420] !motor_enable)
        else $error("motor output held too long after brake");
    a_alarm_trip: assert property ($rose(alarm_in) && motor_enable |-> ##[1:820] brake_interlock_out)
        else $error("brake not applied after alarm");
    a_motor_cause: assert property ($rose(motor_enable) |-> $past(servo_on_in) && !$past(alarm_in))
        else $error("motor on without servo request");
    a_apb_ready: assert property (psel |-> pready)
        else $error("pready low");
    a_apb_error: assert property (psel && penable |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    a_pin_route: assert property (sel_r != 2'h0 && $stable(sel_r) && $stable(brake_interlock_out)
        |-> out_pair_n[sel_r - 2'h1] == !brake_interlock_out)
        else $error("brake not on selected pin pair");
endmodule : hbi_top_asserts
bind hbi_top hbi_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .servo_on_in(servo_on_in), .alarm_in(alarm_in), .motor_enable(motor_enable),
    .brake_interlock_out(brake_interlock_out), .out_pair_n(out_pair_n));
`default_nettype wire

// [verification/hbi_motor_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hbi_motor_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        motor_enable,
    input  wire logic        brake_interlock_out,
    input  wire logic [13:0] spd_cmd,
    output logic [13:0]      motor_speed
);
    // Shaft follows the command only with torque on and the brake free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_speed <= 14'h0;
        end else if (!motor_enable) begin
            motor_speed <= 14'h0;
        end else if (!brake_interlock_out) begin
            motor_speed <= spd_cmd;
        end
    end
endmodule : hbi_motor_model
`default_nettype wire

// [verification/tb_holding_brake_interlock.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_holding_brake_interlock;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, motor_enable, brake_interlock_out, servo_on_in = 0, alarm_in = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [2:0]  out_pair_n;
    logic [13:0] motor_speed, spd_cmd = '0;
    logic [6:0]  stat = '0;
    logic        err_seen = 1'b0;
    int          err_total = 0, n_tests = 0, n;
    logic [11:0] ra [5] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
    logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h64, 32'h32, 32'hD2};
    logic [31:0] bad [5] = '{32'h4, 32'h33, 32'h2711, 32'h65, 32'h29B};
    logic [31:0] top [5] = '{32'h3, 32'h32, 32'h2710, 32'h64, 32'h29A};
    hbi_top #(.TICK_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .servo_on_in(servo_on_in), .alarm_in(alarm_in),
        .motor_speed(motor_speed), .position_complete(stat[0]), .speed_coincide(stat[1]),
        .rotation_detect(stat[2]), .servo_ready(stat[3]), .current_limit(stat[4]),
        .overload_warn(stat[5]), .overload_fault(stat[6]), .motor_enable(motor_enable),
        .brake_interlock_out(brake_interlock_out), .out_pair_n(out_pair_n));
    hbi_motor_model u_mot (.pclk(pclk), .presetn(presetn), .motor_enable(motor_enable),
        .brake_interlock_out(brake_interlock_out), .spd_cmd(spd_cmd), .motor_speed(motor_speed));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer; a read compares against d
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        if (!w) chk($sformatf("reg %h", a), d, prdata);
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, {31'h0, pready});
            stop_test();
        end
    endtask : acc
    task automatic wt(input logic b, input logic v);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((b ? brake_interlock_out : motor_enable) !== v && n < 2000);
        if (n >= 2000) begin
            chk("wait", 32'(v), 32'(~v));
            stop_test();
        end
    endtask : wt
    task automatic srv_up();
        servo_on_in <= 1'b1;
        wt(1'b0, 1'b1);
        chk("brake", 0, 32'(brake_interlock_out));
        acc(0, 12'h014, 32'h12);
    endtask : srv_up
    initial begin
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) acc(0, ra[i], rv[i]);
        acc(0, 12'h014, 32'h1);
        for (int i = 0; i < 5; i++) begin
            acc(1, ra[i], top[i]);
            acc(0, ra[i], top[i]);
            acc(1, ra[i], bad[i]);
            acc(0, ra[i], top[i]);
            acc(1, ra[i], rv[i]);
        end
        acc(1, 12'h010, 32'h6D);
        acc(1, 12'h010, 32'hAA);
        acc(0, 12'h010, 32'hD2);
        acc(1, 12'h018, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err_seen});
        acc(1, 12'h002, 32'h3);
        chk("pslverr", 32'h1, {31'h0, err_seen});
        acc(0, 12'h000, 32'h0);
        chk("pslverr", 32'h0, {31'h0, err_seen});
        for (int p = 0; p < 3; p++)
            for (int d = (p == 0 ? 0 : 1); d < 7; d++) begin
                acc(1, 12'h010, 32'(111 + (d - 1) * (p == 0 ? 1 : p == 1 ? 10 : 100)));
                for (int i = 0; i < 8; i++) begin
                    stat <= 7'(1 << i);
                    repeat (3) @(posedge pclk);
                    chk("pair", {31'h0, (d == 0 ? ~(stat[0] | stat[1]) : d == 4 ? 1'b0
                        : ~stat[d < 4 ? d + 1 : d])}, 32'(out_pair_n[p]));
                end
            end
        for (int s = 0; s < 4; s++) begin
            acc(1, 12'h000, 32'(s));
            repeat (3) @(posedge pclk);
            chk("pins", 32'(s == 0 ? 3'h7 : 3'h7 & ~(3'h1 << (s - 1))), 32'(out_pair_n));
        end
        acc(1, 12'h000, 32'h0);
        spd_cmd <= 14'h63;
        srv_up();
        servo_on_in <= 1'b0;
        wt(1'b1, 1'b1);
        chk("motor", 0, 32'(motor_enable));
        acc(1, 12'h004, 32'h3);
        srv_up();
        servo_on_in <= 1'b0;
        wt(1'b1, 1'b1);
        acc(0, 12'h014, 32'h23);
        wt(1'b0, 1'b0);
        chk("stop delay", 1, 32'(n >= 12 && n <= 26));
        acc(1, 12'h004, 32'h0);
        acc(1, 12'h00C, 32'h4);
        spd_cmd <= 14'h64;
        srv_up();
        alarm_in <= 1'b1;
        wt(1'b1, 1'b1);
        chk("motor", 0, 32'(motor_enable));
        chk("run timeout", 1, 32'(n >= 22 && n <= 38));
        alarm_in <= 1'b0;
        acc(1, 12'h00C, 32'h64);
        spd_cmd <= 14'h1F4;
        srv_up();
        servo_on_in <= 1'b0;
        repeat (40) @(posedge pclk);
        acc(0, 12'h014, 32'h32);
        spd_cmd <= 14'h63;
        wt(1'b1, 1'b1);
        chk("run speed", 1, 32'(n <= 6 && motor_enable === 1'b0));
        stop_test();
    end
endmodule : tb_holding_brake_interlock
`default_nettype wire
